// ===== hdl/port_pin_configuration.sv
`timescale 1ns/100ps
module port_pin_configuration (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Secondary pin-select fields
   input wire logic [1:0] timer_four_pin_choice,
   input wire logic timer_three_pin_choice,
   // Raw pin levels
   input wire logic [7:0] port0_pin_in,
   input wire logic [7:0] port1_pin_in,
   input wire logic [7:0] port2_pin_in,
   input wire logic [7:0] port3_pin_in,
   input wire logic [7:0] port4_pin_in,
   // Port data as read by software
   output logic [7:0] port0_read_data,
   output logic [7:0] port1_read_data,
   output logic [7:0] port2_read_data,
   output logic [7:0] port3_read_data,
   output logic [7:0] port4_read_data,
   // Effective digital output enables
   output logic [7:0] port0_output_en,
   output logic [7:0] port1_output_en,
   output logic [7:0] port2_output_en,
   output logic [7:0] port3_output_en,
   output logic [7:0] port4_output_en,
   // Analog mode per pin
   output logic [7:0] port1_analog_en,
   output logic [7:0] port2_analog_en,
   output logic [7:0] port3_analog_en,
   output logic [7:0] port4_analog_en,
   // Effective pull-ups
   output logic [7:0] port0_pullup_en,
   output logic [7:0] port1_pullup_en,
   output logic [7:0] port2_pullup_en,
   output logic [7:0] port3_pullup_en,
   output logic [7:0] port4_pullup_en,
   // Special pin options
   output logic pin11_pulldown,
   output logic pin01_pulldown,
   output logic pin01_open_drain,
   output logic pin00_open_drain,
   output logic pin11_highvolt_input,
   output logic pin10_highvolt_input,
   output logic pin13_enhanced_drive,
   // Function routing
   output logic spi_slave_miso_idle_state,
   output logic first_serial_route_enable,
   output logic second_serial_route_enable,
   output logic [2:0] timer_four_pin_route,
   output logic [1:0] timer_three_pin_route,
   output logic timer_two_route_enable,
   output logic timer_two_alt_route_enable,
   output logic x_phase_output_enable
);
   import pin_cfg_pkg::*;

   // ==========================================================
   // Register storage
   logic [7:0] port0_direction_q, port1_direction_q, port2_direction_q, port3_direction_q;
   logic [7:0] port4_direction_q, pin_function_select_q, port4_analog_q, port4_pullup_q;
   logic [7:0] port1_analog_q, port2_analog_q, port3_analog_q;
   logic [7:0] port0_pullup_q, port1_pullup_q, port2_pullup_q, port3_pullup_q;

   // ==========================================================
   // Bus decode
   logic [15:0] index;
   logic aligned, mapped, setup, wr_access, pslverr_q;
   logic [7:0] wbyte, read_d;
   logic [31:0] prdata_q;
   assign index = paddr[17:2];
   assign aligned = (paddr[1:0] == 2'h0);
   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite & mapped;
   assign wbyte = pwdata[7:0];
   always_comb begin
      read_d = 8'h00;
      mapped = aligned;
      case (index)
         IDX_PORT0_DIRECTION: read_d = port0_direction_q;
         IDX_PORT1_DIRECTION: read_d = port1_direction_q;
         IDX_PORT2_DIRECTION: read_d = port2_direction_q;
         IDX_PORT3_DIRECTION: read_d = port3_direction_q;
         IDX_PORT4_DIRECTION: read_d = port4_direction_q;
         IDX_PORT1_ANALOG: read_d = port1_analog_q;
         IDX_PORT2_ANALOG: read_d = port2_analog_q;
         IDX_PORT3_ANALOG: read_d = port3_analog_q;
         IDX_PORT4_ANALOG: read_d = port4_analog_q;
         IDX_PORT0_PULLUP: read_d = port0_pullup_q;
         IDX_PORT1_PULLUP: read_d = port1_pullup_q;
         IDX_PORT2_PULLUP: read_d = port2_pullup_q;
         IDX_PORT3_PULLUP: read_d = port3_pullup_q;
         IDX_PORT4_PULLUP: read_d = port4_pullup_q;
         IDX_PIN_FUNCTION_SELECT: read_d = pin_function_select_q;
         default: mapped = 1'b0;
      endcase
      if (!aligned) read_d = 8'h00;
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= {24'h00_0000, read_d};
         pslverr_q <= ~mapped;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // ==========================================================
   // Direction registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port0_direction_q <= CFG_RESET;
         port1_direction_q <= CFG_RESET;
         port2_direction_q <= CFG_RESET;
         port3_direction_q <= CFG_RESET;
         port4_direction_q <= CFG_RESET;
      end else if (wr_access) begin
         if (index == IDX_PORT0_DIRECTION) port0_direction_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT1_DIRECTION) port1_direction_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT2_DIRECTION) port2_direction_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT3_DIRECTION) port3_direction_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT4_DIRECTION) port4_direction_q <= wbyte & MASK_PORT4_DIRECTION;
      end
   end

   // ==========================================================
   // Analog registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port1_analog_q <= CFG_RESET;
         port2_analog_q <= CFG_RESET;
         port3_analog_q <= CFG_RESET;
         port4_analog_q <= CFG_RESET;
      end else if (wr_access) begin
         if (index == IDX_PORT1_ANALOG) port1_analog_q <= wbyte & MASK_PORT1_ANALOG;
         if (index == IDX_PORT2_ANALOG) port2_analog_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT3_ANALOG) port3_analog_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT4_ANALOG) port4_analog_q <= wbyte & MASK_PORT4_ANALOG;
      end
   end

   // ==========================================================
   // Pull-up registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port0_pullup_q <= CFG_RESET;
         port1_pullup_q <= CFG_RESET;
         port2_pullup_q <= CFG_RESET;
         port3_pullup_q <= CFG_RESET;
         port4_pullup_q <= CFG_RESET;
      end else if (wr_access) begin
         if (index == IDX_PORT0_PULLUP) port0_pullup_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT1_PULLUP) port1_pullup_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT2_PULLUP) port2_pullup_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT3_PULLUP) port3_pullup_q <= wbyte & MASK_FULL;
         if (index == IDX_PORT4_PULLUP) port4_pullup_q <= wbyte & MASK_PORT4_PULLUP;
      end
   end

   // ==========================================================
   // Function select register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_function_select_q <= CFG_RESET;
      end else if (wr_access && index == IDX_PIN_FUNCTION_SELECT) begin
         pin_function_select_q <= wbyte & MASK_FULL;
      end
   end

   // ==========================================================
   // Analog decode
   logic pin13_special;
   logic [7:0] an1_d, an2_d, an3_d, an4_d;
   assign pin13_special = port1_analog_q[POS_PIN13_SPECIAL_MODE];
   assign an1_d = {port1_analog_q[7:4], pin13_special & ~port1_direction_q[3], 3'h0};
   assign an2_d = port2_analog_q;
   assign an3_d = {2'h0, port3_analog_q[5:0]};
   assign an4_d = {2'h0, port4_analog_q[POS_PIN45_ANALOG], 5'h00};

   // ==========================================================
   // Pin configuration outputs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port1_analog_en <= 8'h00;
         port2_analog_en <= 8'h00;
         port3_analog_en <= 8'h00;
         port4_analog_en <= 8'h00;
         port0_output_en <= 8'h00;
         port1_output_en <= 8'h00;
         port2_output_en <= 8'h00;
         port3_output_en <= 8'h00;
         port4_output_en <= 8'h00;
         pin13_enhanced_drive <= 1'b0;
      end else begin
         port1_analog_en <= an1_d;
         port2_analog_en <= an2_d;
         port3_analog_en <= an3_d;
         port4_analog_en <= an4_d;
         port0_output_en <= port0_direction_q;
         port1_output_en <= port1_direction_q & ~an1_d;
         port2_output_en <= port2_direction_q & ~an2_d;
         port3_output_en <= port3_direction_q & ~an3_d;
         port4_output_en <= port4_direction_q & ~an4_d;
         pin13_enhanced_drive <= pin13_special & port1_direction_q[3];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         port0_pullup_en <= 8'h00;
         port1_pullup_en <= 8'h00;
         port2_pullup_en <= 8'h00;
         port3_pullup_en <= 8'h00;
         port4_pullup_en <= 8'h00;
      end else begin
         port0_pullup_en <= port0_pullup_q;
         port1_pullup_en <= {port1_pullup_q[7:2] & ~{an1_d[7:6], 4'h0}, 2'h0};
         port2_pullup_en <= port2_pullup_q & ~an2_d;
         port3_pullup_en <= port3_pullup_q & ~an3_d;
         port4_pullup_en <= port4_pullup_q;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin11_pulldown <= 1'b0;
         pin01_pulldown <= 1'b0;
         pin01_open_drain <= 1'b0;
         pin00_open_drain <= 1'b0;
         pin11_highvolt_input <= 1'b0;
         pin10_highvolt_input <= 1'b0;
      end else begin
         pin11_pulldown <= port3_analog_q[POS_PIN11_PULLDOWN];
         pin01_pulldown <= port3_analog_q[POS_PIN01_PULLDOWN];
         pin01_open_drain <= port1_analog_q[POS_PIN01_OPEN_DRAIN];
         pin00_open_drain <= port1_analog_q[POS_PIN00_OPEN_DRAIN];
         pin11_highvolt_input <= port1_pullup_q[POS_PIN11_HIGHVOLT];
         pin10_highvolt_input <= port1_pullup_q[POS_PIN10_HIGHVOLT];
      end
   end

   // ==========================================================
   // Function routing outputs
   logic [2:0] t4_route_d;
   logic [1:0] t3_route_d;
   always_comb begin
      t4_route_d = 3'h0;
      if (pin_function_select_q[POS_TIMER_FOUR]) begin
         case (timer_four_pin_choice)
            2'h0: t4_route_d = 3'h1;
            2'h2: t4_route_d = 3'h4;
            default: t4_route_d = 3'h2;
         endcase
      end
   end

   always_comb begin
      t3_route_d = 2'h0;
      if (pin_function_select_q[POS_TIMER_THREE]) begin
         t3_route_d = timer_three_pin_choice ? 2'h2 : 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         spi_slave_miso_idle_state <= 1'b0;
         first_serial_route_enable <= 1'b0;
         second_serial_route_enable <= 1'b0;
         timer_four_pin_route <= 3'h0;
         timer_three_pin_route <= 2'h0;
         timer_two_route_enable <= 1'b0;
         timer_two_alt_route_enable <= 1'b0;
         x_phase_output_enable <= 1'b0;
      end else begin
         spi_slave_miso_idle_state <= pin_function_select_q[POS_MISO_IDLE_STATE];
         first_serial_route_enable <= pin_function_select_q[POS_FIRST_SERIAL];
         second_serial_route_enable <= pin_function_select_q[POS_SECOND_SERIAL];
         timer_four_pin_route <= t4_route_d;
         timer_three_pin_route <= t3_route_d;
         timer_two_route_enable <= pin_function_select_q[POS_TIMER_TWO];
         timer_two_alt_route_enable <= pin_function_select_q[POS_TIMER_TWO_ALT];
         x_phase_output_enable <= pin_function_select_q[POS_X_PHASE];
      end
   end

   // ==========================================================
   // Pin input synchronisers and read masking
   logic [4:0][7:0] pin_raw, sync1_q, sync2_q, read_mask, read_q;
   assign pin_raw[0] = port0_pin_in;
   assign pin_raw[1] = port1_pin_in;
   assign pin_raw[2] = port2_pin_in;
   assign pin_raw[3] = port3_pin_in;
   assign pin_raw[4] = port4_pin_in;
   assign read_mask[0] = 8'h00;
   assign read_mask[1] = an1_d;
   assign read_mask[2] = an2_d;
   assign read_mask[3] = an3_d;
   assign read_mask[4] = an4_d | ~MASK_PORT4_DIRECTION;
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_port
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               sync1_q[g] <= 8'h00;
               sync2_q[g] <= 8'h00;
               read_q[g] <= 8'h00;
            end else begin
               sync1_q[g] <= pin_raw[g];
               sync2_q[g] <= sync1_q[g];
               read_q[g] <= sync2_q[g] & ~read_mask[g];
            end
         end
      end
   endgenerate

   assign port0_read_data = read_q[0];
   assign port1_read_data = read_q[1];
   assign port2_read_data = read_q[2];
   assign port3_read_data = read_q[3];
   assign port4_read_data = read_q[4];

endmodule

// ===== hdl/pin_cfg_pkg.sv
package pin_cfg_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [15:0] IDX_PORT4_DIRECTION = 16'h00E9;
   localparam logic [15:0] IDX_PORT0_DIRECTION = 16'h00FC;
   localparam logic [15:0] IDX_PORT1_DIRECTION = 16'h00FD;
   localparam logic [15:0] IDX_PORT2_DIRECTION = 16'h00FE;
   localparam logic [15:0] IDX_PORT3_DIRECTION = 16'h00FF;
   localparam logic [15:0] IDX_PORT4_ANALOG = 16'h4047;
   localparam logic [15:0] IDX_PIN_FUNCTION_SELECT = 16'h404C;
   localparam logic [15:0] IDX_PORT1_ANALOG = 16'h4050;
   localparam logic [15:0] IDX_PORT2_ANALOG = 16'h4051;
   localparam logic [15:0] IDX_PORT3_ANALOG = 16'h4052;
   localparam logic [15:0] IDX_PORT0_PULLUP = 16'h4053;
   localparam logic [15:0] IDX_PORT1_PULLUP = 16'h4054;
   localparam logic [15:0] IDX_PORT2_PULLUP = 16'h4055;
   localparam logic [15:0] IDX_PORT3_PULLUP = 16'h4056;
   localparam logic [15:0] IDX_PORT4_PULLUP = 16'h4057;

   // ==========================================================
   // Implemented bit masks
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_PORT4_DIRECTION = 8'h7E;
   localparam logic [7:0] MASK_PORT1_ANALOG = 8'hFB;
   localparam logic [7:0] MASK_PORT4_ANALOG = 8'h40;
   localparam logic [7:0] MASK_PORT4_PULLUP = 8'h7E;

   // ==========================================================
   // Reset value of every configuration register
   localparam logic [7:0] CFG_RESET = 8'h00;

   // ==========================================================
   // Field positions
   localparam int POS_PIN13_SPECIAL_MODE = 3;
   localparam int POS_PIN01_OPEN_DRAIN = 1;
   localparam int POS_PIN00_OPEN_DRAIN = 0;
   localparam int POS_PIN45_ANALOG = 6;
   localparam int POS_PIN11_PULLDOWN = 7;
   localparam int POS_PIN01_PULLDOWN = 6;
   localparam int POS_PIN11_HIGHVOLT = 1;
   localparam int POS_PIN10_HIGHVOLT = 0;
   localparam int POS_MISO_IDLE_STATE = 7;
   localparam int POS_FIRST_SERIAL = 6;
   localparam int POS_SECOND_SERIAL = 5;
   localparam int POS_TIMER_FOUR = 4;
   localparam int POS_TIMER_THREE = 3;
   localparam int POS_TIMER_TWO = 2;
   localparam int POS_TIMER_TWO_ALT = 1;
   localparam int POS_X_PHASE = 0;

endpackage

// ===== dv/pin_cfg_monitor.sv
`timescale 1ns/100ps
module pin_cfg_monitor (
   // Clock, reset and APB
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Pin configuration
   input wire logic [7:0] port0_output_en,
   input wire logic [7:0] port1_output_en,
   input wire logic [7:0] port2_output_en,
   input wire logic [7:0] port4_output_en,
   input wire logic [7:0] port1_analog_en,
   input wire logic [7:0] port2_analog_en,
   input wire logic [7:0] port3_analog_en,
   input wire logic [7:0] port1_pullup_en,
   input wire logic [7:0] port2_pullup_en,
   input wire logic [7:0] port3_pullup_en,
   input wire logic [7:0] port4_pullup_en,
   input wire logic pin13_enhanced_drive,
   // Function routing
   input wire logic first_serial_route_enable,
   input wire logic x_phase_output_enable,
   input wire logic [2:0] timer_four_pin_route,
   input wire logic [1:0] timer_three_pin_route
);
   import pin_cfg_pkg::*;
   // ==========================================================
   // Clocking and helpers
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic acc_wr = psel & penable & pwrite;
   // ==========================================================
   // Assertions
   read_upper_zero_a: assert property (prdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("misaligned access not refused");
   dir_port0_a: assert property (acc_wr && paddr == 18'h003F0 |->
      ##2 port0_output_en == $past(pwdata[7:0], 2)) else $error("port0 direction not applied");
   port4_reserved_a: assert property (((port4_output_en | port4_pullup_en) & 8'h81) == 8'h00)
      else $error("port4 reserved pin active");
   analog_no_drive_a: assert property ((port2_output_en & port2_analog_en) == 8'h00
      && (port1_output_en & port1_analog_en) == 8'h00) else $error("analog pin driven");
   analog_no_pull_a: assert property ((port2_pullup_en & port2_analog_en) == 8'h00
      && (port3_pullup_en[5:0] & port3_analog_en[5:0]) == 6'h00
      && (port1_pullup_en[7:6] & port1_analog_en[7:6]) == 2'b00) else $error("analog pull-up on");
   pin13_drive_a: assert property (pin13_enhanced_drive |-> port1_output_en[3]
      && !port1_analog_en[3]) else $error("pin 1.3 mode inconsistent");
   port1_pull_low_a: assert property (port1_pullup_en[1:0] == 2'b00)
      else $error("port1 low pull-ups active");
   timer_route_a: assert property ($onehot0(timer_four_pin_route)
      && $onehot0(timer_three_pin_route)) else $error("timer route not one-hot");
   fsel_apply_a: assert property (acc_wr && paddr == 18'h10130 |-> ##2
      {first_serial_route_enable, x_phase_output_enable} == {$past(pwdata[6], 2),
      $past(pwdata[0], 2)}) else $error("function select not applied");
endmodule
bind port_pin_configuration pin_cfg_monitor u_pin_cfg_monitor (.*);

// ===== dv/pin_board_model.sv
`timescale 1ns/100ps
module pin_board_model (
   // Clock
   input wire logic core_clk,
   // Levels requested by the bench
   input wire logic [39:0] level_set,
   // Pin levels seen by the device
   output logic [7:0] port0_pin_in,
   output logic [7:0] port1_pin_in,
   output logic [7:0] port2_pin_in,
   output logic [7:0] port3_pin_in,
   output logic [7:0] port4_pin_in
);
   // ==========================================================
   // Board levels, changed just after the clock edge
   always @(posedge core_clk) begin
      {port4_pin_in, port3_pin_in, port2_pin_in, port1_pin_in, port0_pin_in} <= level_set;
   end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import pin_cfg_pkg::*;
   // ==========================================================
   // Signals
   logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, timer_three_pin_choice;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] timer_four_pin_choice, timer_three_pin_route;
   logic [2:0] timer_four_pin_route;
   logic [39:0] level_set;
   logic [7:0] port0_pin_in, port1_pin_in, port2_pin_in, port3_pin_in, port4_pin_in;
   logic [7:0] port0_read_data, port1_read_data, port2_read_data, port3_read_data;
   logic [7:0] port4_read_data, port0_output_en, port1_output_en, port2_output_en;
   logic [7:0] port3_output_en, port4_output_en, port1_analog_en, port2_analog_en;
   logic [7:0] port3_analog_en, port4_analog_en, port0_pullup_en, port1_pullup_en;
   logic [7:0] port2_pullup_en, port3_pullup_en, port4_pullup_en, w;
   logic pin11_pulldown, pin01_pulldown, pin01_open_drain, pin00_open_drain;
   logic pin11_highvolt_input, pin10_highvolt_input, pin13_enhanced_drive;
   logic spi_slave_miso_idle_state, first_serial_route_enable, second_serial_route_enable;
   logic timer_two_route_enable, timer_two_alt_route_enable, x_phase_output_enable;
   int fail_count = 0;
   int n_checks = 0;
   logic [17:0] adr [15] = '{18'h003A4, 18'h003F0, 18'h003F4, 18'h003F8, 18'h003FC,
      18'h1011C, 18'h10130, 18'h10140, 18'h10144, 18'h10148, 18'h1014C, 18'h10150,
      18'h10154, 18'h10158, 18'h1015C};
   logic [7:0] mk [15] = '{8'h7E, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h40, 8'hFF, 8'hFB,
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7E};
   port_pin_configuration u_port_pin_configuration (.*);
   pin_board_model u_pin_board_model (.*);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= 1'b1; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] exp, input logic err);
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= 1'b0; paddr <= a;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      n_checks++;
      if (prdata !== exp || pslverr !== err) begin
         fail_count++;
         $display("CHECK FAILED at %0t: read %h gave %h err %b", $time, a, prdata, pslverr);
      end
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Tests
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 18'h0;
      pwdata = 32'h0; timer_four_pin_choice = 2'b00; timer_three_pin_choice = 1'b0;
      level_set = 40'h0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 15; i++) rd(adr[i], 32'h0, 1'b0);
      for (int i = 0; i < 15; i++) begin
         w = (i == 10) ? 8'hFD : 8'hFF;
         wr(adr[i], {24'hFFFFFF, w});
         rd(adr[i], {24'h0, w & mk[i]}, 1'b0);
      end
      level_set <= 40'hFF_FF_FF_FF_FF;
      look(4);
      chk({port4_output_en, port3_output_en, port2_output_en, port1_output_en,
         port0_output_en}, 40'h5E_C0_00_0F_FF);
      chk({port4_analog_en, port3_analog_en, port2_analog_en, port1_analog_en},
         32'h20_3F_FF_F0);
      chk({port4_pullup_en, port3_pullup_en, port2_pullup_en, port1_pullup_en,
         port0_pullup_en}, 40'h7E_C0_00_3C_FD);
      chk({pin11_pulldown, pin01_pulldown, pin01_open_drain, pin00_open_drain}, 4'hF);
      chk({pin11_highvolt_input, pin10_highvolt_input, pin13_enhanced_drive}, 3'h7);
      chk({spi_slave_miso_idle_state, first_serial_route_enable, second_serial_route_enable,
         timer_two_route_enable, timer_two_alt_route_enable, x_phase_output_enable},
         6'h3F);
      chk({port4_read_data, port3_read_data, port2_read_data, port1_read_data,
         port0_read_data}, 40'h5E_C0_00_0F_FF);
      @(posedge core_clk);
      for (int c = 0; c < 4; c++) begin
         timer_four_pin_choice <= c[1:0];
         timer_three_pin_choice <= c[0];
         look(2);
         chk(timer_four_pin_route, (c == 2) ? 3'b100 : (c[0] ? 3'b010 : 3'b001));
         chk(timer_three_pin_route, c[0] ? 2'b10 : 2'b01);
         @(posedge core_clk);
      end
      wr(18'h10130, 32'h0);
      look(2);
      chk({timer_four_pin_route, timer_three_pin_route, first_serial_route_enable,
         x_phase_output_enable}, 7'h00);
      for (int m = 0; m < 4; m++) begin
         wr(18'h10140, {28'h0, m[1], 3'b000});
         wr(18'h003F4, {28'h0, m[0], 3'b000});
         look(2);
         chk({pin13_enhanced_drive, port1_analog_en[3], port1_output_en[3]},
            {m[1] & m[0], m[1] & ~m[0], m[0]});
      end
      rd(18'h00000, 32'h0, 1'b1);
      wr(18'h003F2, 32'h0);
      rd(18'h003F2, 32'h0, 1'b1);
      rd(18'h003F0, 32'hFF, 1'b0);
      rstn <= 1'b0;
      @(negedge core_clk);
      chk({port0_output_en, port0_pullup_en, port1_analog_en}, 40'h0);
      @(posedge core_clk);
      rstn <= 1'b1;
      rd(18'h003F0, 32'h0, 1'b0);
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      tally_and_finish;
   end
endmodule
